// ==== sacs_sequencer.sv ====
/*
 sacs_sequencer: conversion sequencer of a serial successive-approximation converter.
 assumes: ref_clk_in is the conversion clock; serial_clock_in is the host's serial clock,
 which may stop between frames; the analog code arrives as a level word sampled here.
*/
module sacs_sequencer #(
   parameter int WAKE_CYCLES = sacs_pkg::WAKE_CYC
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire logic serial_clock_in,
   input wire logic chip_select_n_in,
   input wire logic serial_input_in,
   input wire logic start_sample_strobe_n_in,
   input wire logic power_down_pin_in,
   input wire logic [sacs_pkg::CODE_W-1:0] analog_code_in,
   output logic serial_output_out,
   output logic serial_output_oe_out,
   output logic data_out_ready_n_out,
   output logic eoc_out
);
   // serial-clock domain
   logic s_rst_n;
   logic [3:0] bit_q, bit_d;
   logic [sacs_pkg::CMD_W-1:0] shin_q, shin_d;
   logic [sacs_pkg::CMD_W-1:0] cmd_q, cmd_d;
   logic cmd_tgl_q, cmd_tgl_d;
   logic [sacs_pkg::CODE_W-1:0] shout_q, shout_d;
   logic dor_n_q, dor_n_d;
   logic res_tgl_s;
   logic res_seen_q, res_seen_d;

   // conversion-clock domain
   logic [2:0] pins_s;
   logic [sacs_pkg::CODE_W-1:0] code_meta_q, code_q;
   logic cmd_tgl_s;
   logic cmd_seen_q, cmd_seen_d;
   sacs_pkg::sacs_state_t st_q, st_d;
   logic [sacs_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [1:0] acq_sel_q, acq_sel_d;
   logic res8_q, res8_d;
   logic armed_q, armed_d;
   logic az_first_q, az_first_d;
   logic sync_to_cal_q, sync_to_cal_d;
   logic sw_down_q, sw_down_d;
   logic [sacs_pkg::CODE_W-1:0] hold_q, hold_d;
   logic [sacs_pkg::CODE_W-1:0] result_q, result_d;
   logic res_tgl_q, res_tgl_d;
   logic eoc_q, eoc_d;
   logic cmd_new;
   logic [3:0] op;
   logic [sacs_pkg::CNT_W-1:0] acq_len;

   // serial side sees reset only while its clock runs; it idles harmlessly otherwise
   sacs_sync #(.W(2)) u_sync_s (
      .clk_in(serial_clock_in),
      .d_in({nrst_in, res_tgl_q}),
      .q_out({s_rst_n, res_tgl_s})
   );

   // frame position and ready are cleared by chip select alone: the serial clock may stop between frames
   always_comb begin
      bit_d = bit_q;
      dor_n_d = dor_n_q;
      if (bit_q != sacs_pkg::BIT_OUT_LAST) begin
         bit_d = bit_q + 4'h1;
      end
      // ready goes low at the first edge of a frame and high again at the ninth
      if (bit_q == 4'h0) begin
         dor_n_d = 1'b0;
      end
      if (bit_q == sacs_pkg::BIT_READY_HIGH) begin
         dor_n_d = 1'b1;
      end
   end

   always_ff @(posedge serial_clock_in or posedge chip_select_n_in) begin
      if (chip_select_n_in) begin
         bit_q <= 4'h0;
         dor_n_q <= 1'b1;
      end else if (!s_rst_n) begin
         bit_q <= 4'h0;
         dor_n_q <= 1'b1;
      end else begin
         bit_q <= bit_d;
         dor_n_q <= dor_n_d;
      end
   end

   always_comb begin
      shin_d = shin_q;
      cmd_d = cmd_q;
      cmd_tgl_d = cmd_tgl_q;
      shout_d = shout_q;
      res_seen_d = res_seen_q;
      if (!chip_select_n_in) begin
         shin_d = {shin_q[sacs_pkg::CMD_W-2:0], serial_input_in};
         if (bit_q == 4'h0) begin
            // result word is stable in the core while its toggle is in flight
            // limitation: a frame opened just as a conversion ends may read a mixed word
            shout_d = result_q;
            res_seen_d = res_tgl_s;
         end else begin
            shout_d = {shout_q[sacs_pkg::CODE_W-2:0], 1'b0};
         end
         if (bit_q == sacs_pkg::BIT_CMD_LAST) begin
            cmd_d = {shin_q[sacs_pkg::CMD_W-2:0], serial_input_in};
            cmd_tgl_d = ~cmd_tgl_q;
         end
      end
   end

   always_ff @(posedge serial_clock_in) begin
      if (!s_rst_n) begin
         shin_q <= sacs_pkg::CMD_RST;
         cmd_q <= sacs_pkg::CMD_RST;
         cmd_tgl_q <= 1'b0;
         shout_q <= sacs_pkg::RESULT_RST;
         res_seen_q <= 1'b0;
      end else begin
         shin_q <= shin_d;
         cmd_q <= cmd_d;
         cmd_tgl_q <= cmd_tgl_d;
         shout_q <= shout_d;
         res_seen_q <= res_seen_d;
      end
   end

   assign serial_output_out = shout_q[sacs_pkg::CODE_W-1];
   assign serial_output_oe_out = ~chip_select_n_in;
   assign data_out_ready_n_out = dor_n_q;

   // conversion side
   sacs_sync #(.W(3)) u_sync_c (
      .clk_in(ref_clk_in),
      .d_in({cmd_tgl_q, start_sample_strobe_n_in, power_down_pin_in}),
      .q_out(pins_s)
   );
   // pins_s[1] is the strobe and pins_s[0] the power-down pin, both two flops deep
   assign cmd_tgl_s = pins_s[2];

   // per-bit double flop on the sampled analog code, frozen with the core
   always_ff @(posedge ref_clk_in) begin
      if (ce_in) begin
         code_meta_q <= analog_code_in;
         code_q <= code_meta_q;
      end
   end

   // command word was written several conversion clocks before its toggle arrives here
   assign cmd_new = cmd_tgl_s ^ cmd_seen_q;
   assign op = cmd_q[sacs_pkg::CMD_OP_HI:sacs_pkg::CMD_OP_LO];

   // length is taken when sampling starts; a later convert command does not stretch it
   always_comb begin
      unique case (acq_sel_q)
         2'h0: acq_len = sacs_pkg::CNT_W'(sacs_pkg::ACQ_6_CYC);
         2'h1: acq_len = sacs_pkg::CNT_W'(sacs_pkg::ACQ_10_CYC);
         2'h2: acq_len = sacs_pkg::CNT_W'(sacs_pkg::ACQ_18_CYC);
         2'h3: acq_len = sacs_pkg::CNT_W'(sacs_pkg::ACQ_34_CYC);
      endcase
   end

   always_comb begin
      st_d = st_q;
      cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
      acq_sel_d = acq_sel_q;
      res8_d = res8_q;
      armed_d = armed_q;
      az_first_d = az_first_q;
      sync_to_cal_d = sync_to_cal_q;
      sw_down_d = sw_down_q;
      hold_d = hold_q;
      result_d = result_q;
      res_tgl_d = res_tgl_q;
      cmd_seen_d = cmd_tgl_s;
      if (cmd_new) begin
         unique case (op)
            sacs_pkg::OP_CONVERT: begin
               acq_sel_d = cmd_q[sacs_pkg::CMD_ACQ_HI:sacs_pkg::CMD_ACQ_LO];
               res8_d = cmd_q[sacs_pkg::CMD_RES8_BIT];
               az_first_d = cmd_q[sacs_pkg::CMD_AZ_BIT];
               armed_d = 1'b1;
            end
            sacs_pkg::OP_POWER_DOWN: sw_down_d = 1'b1;
            sacs_pkg::OP_POWER_UP: sw_down_d = 1'b0;
            default: ;
         endcase
      end
      // power-down aborts any operation in flight; a cut conversion leaves the old result
      if (pins_s[0] || sw_down_d) begin
         st_d = sacs_pkg::SACS_OFF;
      end else begin
         unique case (st_q)
            sacs_pkg::SACS_OFF: begin
               st_d = sacs_pkg::SACS_WAKE;
               cnt_d = sacs_pkg::CNT_W'(WAKE_CYCLES - 1);
            end
            // wake counts from the first cycle with no power-down request seen
            sacs_pkg::SACS_WAKE: begin
               if (cnt_q == '0) begin
                  st_d = sacs_pkg::SACS_IDLE;
               end
            end
            sacs_pkg::SACS_IDLE: begin
               if (cmd_new && (op == sacs_pkg::OP_CALIBRATE || op == sacs_pkg::OP_AUTOZERO)) begin
                  st_d = sacs_pkg::SACS_SYNC;
                  sync_to_cal_d = (op == sacs_pkg::OP_CALIBRATE);
                  cnt_d = sacs_pkg::CNT_W'(sacs_pkg::SYNC_CYC - 1);
               end else if (armed_q && !pins_s[1]) begin
                  // strobe seen within a few conversion clocks of its edge
                  // a convert command landing in this same cycle re-arms: the set wins over the clear
                  if (!(cmd_new && op == sacs_pkg::OP_CONVERT)) begin
                     armed_d = 1'b0;
                  end
                  if (az_first_q) begin
                     st_d = sacs_pkg::SACS_SYNC;
                     sync_to_cal_d = 1'b0;
                     cnt_d = sacs_pkg::CNT_W'(sacs_pkg::SYNC_CYC - 1);
                  end else begin
                     st_d = sacs_pkg::SACS_ACQ;
                     cnt_d = acq_len - 1'b1;
                  end
               end
            end
            sacs_pkg::SACS_SYNC: begin
               if (cnt_q == '0) begin
                  st_d = sync_to_cal_q ? sacs_pkg::SACS_CAL : sacs_pkg::SACS_AZ;
                  cnt_d = sync_to_cal_q ? sacs_pkg::CNT_W'(sacs_pkg::CAL_CYC - 1)
                                        : sacs_pkg::CNT_W'(sacs_pkg::AZ_CYC - 1);
               end
            end
            sacs_pkg::SACS_CAL: begin
               if (cnt_q == '0) begin
                  st_d = sacs_pkg::SACS_IDLE;
               end
            end
            sacs_pkg::SACS_AZ: begin
               if (cnt_q == '0) begin
                  // a stand-alone auto-zero has no sample waiting
                  st_d = az_first_q ? sacs_pkg::SACS_ACQ : sacs_pkg::SACS_IDLE;
                  az_first_d = 1'b0;
                  cnt_d = acq_len - 1'b1;
               end
            end
            sacs_pkg::SACS_ACQ: begin
               if (cnt_q == '0) begin
                  hold_d = code_q;
                  st_d = sacs_pkg::SACS_START_SAMPLE_STROBE;
                  cnt_d = res8_q ? sacs_pkg::CNT_W'(sacs_pkg::START_SAMPLE_STROBE_BYTE_CYC - 1)
                                 : sacs_pkg::CNT_W'(sacs_pkg::START_SAMPLE_STROBE_FULL_CYC - 1);
               end
            end
            sacs_pkg::SACS_START_SAMPLE_STROBE: begin
               if (cnt_q == '0) begin
                  st_d = sacs_pkg::SACS_IDLE;
                  result_d = res8_q ? {hold_q[sacs_pkg::CODE_W-1:4], 4'h0} : hold_q;
                  res_tgl_d = ~res_tgl_q;
               end
            end
         endcase
      end
      // end-of-conversion stays low through calibration, wake and conversion
      eoc_d = (st_d == sacs_pkg::SACS_IDLE);
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         st_q <= sacs_pkg::SACS_IDLE;
         cnt_q <= '0;
         acq_sel_q <= sacs_pkg::ACQ_SEL_RST;
         res8_q <= 1'b0;
         armed_q <= 1'b0;
         az_first_q <= 1'b0;
         sync_to_cal_q <= 1'b0;
         sw_down_q <= 1'b0;
         hold_q <= sacs_pkg::RESULT_RST;
         result_q <= sacs_pkg::RESULT_RST;
         res_tgl_q <= 1'b0;
         cmd_seen_q <= 1'b0;
         eoc_q <= 1'b0;
      end else if (ce_in) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         acq_sel_q <= acq_sel_d;
         res8_q <= res8_d;
         armed_q <= armed_d;
         az_first_q <= az_first_d;
         sync_to_cal_q <= sync_to_cal_d;
         sw_down_q <= sw_down_d;
         hold_q <= hold_d;
         result_q <= result_d;
         res_tgl_q <= res_tgl_d;
         cmd_seen_q <= cmd_seen_d;
         eoc_q <= eoc_d;
      end
   end

   assign eoc_out = eoc_q;
endmodule

// ==== sacs_pkg.sv ====
/*
 sacs_pkg: constants, command codes and state type for the serial converter sequencer.
 assumes: the core runs on the 200 MHz conversion clock, the serial side on the host's serial clock.
*/
// Function
// - full-resolution conversion completes within 44 conversion-clock periods after acquisition
// - eight-bit conversion completes within 21 conversion-clock periods
// - acquisition programmable to 6, 10, 18 or 34 cycles, at most one longer
// - calibration or auto-zero waits 2 to 3 conversion clocks to synchronise first
// - conversion-control input valid-data time is at most 8 serial clocks
// - after power-down pin falls, end-of-conversion rises within 250 us; the code adds two sync clocks and one off cycle to a full 250 us wake
// - after software power-up command, end-of-conversion rises within 250 us; the code adds the command sync and one off cycle to a full 250 us wake
// - conversion timing counts conversion clock; serial timing counts serial clock, may stop
// - with one clock source, acquisition equals exactly the programmed count
package sacs_pkg;
   localparam int CLK_PERIOD_NS = 5;
   localparam int START_SAMPLE_STROBE_FULL_CYC = 44;
   localparam int START_SAMPLE_STROBE_BYTE_CYC = 21;
   localparam int ACQ_6_CYC = 6;
   localparam int ACQ_10_CYC = 10;
   localparam int ACQ_18_CYC = 18;
   localparam int ACQ_34_CYC = 34;
   localparam int SYNC_CYC = 2;
   localparam int CAL_CYC = 4944;
   localparam int AZ_CYC = 76;
   localparam int WAKE_MAX_US = 250;
   localparam int WAKE_TYP_US = 140;
   localparam int WAKE_CYC = WAKE_MAX_US * 1000 / CLK_PERIOD_NS;
   localparam int READY_HIGH_MAX_SCK = 9;
   localparam int STROBE_VALID_SCK = 8;
   localparam int CNT_W = 16;
   localparam int CODE_W = 13;
   localparam int CMD_W = 8;
   // command word layout
   localparam int CMD_OP_HI = 7;
   localparam int CMD_OP_LO = 4;
   localparam int CMD_ACQ_HI = 3;
   localparam int CMD_ACQ_LO = 2;
   localparam int CMD_RES8_BIT = 1;
   localparam int CMD_AZ_BIT = 0;
   localparam logic [3:0] OP_CONVERT = 4'h1;
   localparam logic [3:0] OP_CALIBRATE = 4'h2;
   localparam logic [3:0] OP_AUTOZERO = 4'h3;
   localparam logic [3:0] OP_POWER_UP = 4'h4;
   localparam logic [3:0] OP_POWER_DOWN = 4'h5;
   localparam logic [1:0] ACQ_SEL_RST = 2'h1;
   localparam logic [CODE_W-1:0] RESULT_RST = 13'h0000;
   localparam logic [CMD_W-1:0] CMD_RST = 8'h00;
   localparam logic [3:0] BIT_CMD_LAST = 4'h7;
   localparam logic [3:0] BIT_READY_HIGH = 4'h8;
   localparam logic [3:0] BIT_OUT_LAST = 4'hC;

   typedef enum logic [2:0] {
      SACS_IDLE = 3'h0,
      SACS_ACQ = 3'h1,
      SACS_START_SAMPLE_STROBE = 3'h3,
      SACS_SYNC = 3'h2,
      SACS_CAL = 3'h6,
      SACS_AZ = 3'h7,
      SACS_WAKE = 3'h5,
      SACS_OFF = 3'h4
   } sacs_state_t;
endpackage

// ==== sacs_sync.sv ====
/*
 sacs_sync: two-flop synchroniser for a bundle of independent levels.
 assumes: each bit is a level or a toggle; multi-bit words must not pass through it.
*/
module sacs_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] stab_q;

   always_ff @(posedge clk_in) begin
      meta_q <= d_in;
      stab_q <= meta_q;
   end

   assign q_out = stab_q;
endmodule

// ==== sacs_sequencer_properties.sv ====
/*
 sacs_seq_chk: port-level timing checks for the conversion sequencer, bound onto sacs_sequencer.
 assumes: ce_in held high; the command word is decoded here from the serial pins.
*/
module sacs_seq_chk #(
   parameter int WAKE_CYCLES = sacs_pkg::WAKE_CYC
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic serial_clock_in,
   input wire logic chip_select_n_in,
   input wire logic serial_input_in,
   input wire logic start_sample_strobe_n_in,
   input wire logic power_down_pin_in,
   input wire logic data_out_ready_n_out,
   input wire logic serial_output_oe_out,
   input wire logic eoc_out
);
   logic [7:0] sh_q;
   logic [7:0] cmd_q;
   logic [3:0] bc_q;
   logic [3:0] rh_q;
   logic [15:0] lo_q;
   logic [15:0] wn_q;
   logic wk_q;
   logic rd_q;
   int n_acq;
   wire logic ok = rd_q && !wk_q;
   wire logic cv = ok && cmd_q[7:4] == sacs_pkg::OP_CONVERT;
   assign n_acq = (4 << cmd_q[3:2]) + 2 + (cmd_q[0] ? sacs_pkg::SYNC_CYC + sacs_pkg::AZ_CYC : 0);
   // frame counters clear on chip select alone, as the serial clock stops between frames
   always_ff @(posedge serial_clock_in or posedge chip_select_n_in) begin
      if (chip_select_n_in) begin
         bc_q <= 4'h0;
         rh_q <= 4'h0;
      end else begin
         bc_q <= bc_q + {3'h0, bc_q != 4'hF};
         rh_q <= data_out_ready_n_out ? rh_q + 4'h1 : 4'h0;
      end
   end
   always_ff @(posedge serial_clock_in) begin
      sh_q <= {sh_q[6:0], serial_input_in};
      if (!chip_select_n_in && bc_q == 4'h7) begin
         cmd_q <= {sh_q[6:0], serial_input_in};
      end
   end
   // command read untimed across domains: it is long stable before eoc moves
   always_ff @(posedge ref_clk_in) begin
      lo_q <= eoc_out ? 16'h0 : lo_q + 16'h1;
      wn_q <= (eoc_out || power_down_pin_in) ? 16'h0 : wn_q + 16'h1;
      wk_q <= nrst_in && (power_down_pin_in || (wk_q && !eoc_out));
      // the eoc rise right after reset ends no operation
      rd_q <= nrst_in && (rd_q || eoc_out);
   end
   chk_start_sample_strobe_full: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      $rose(eoc_out) && cv && !cmd_q[1] |-> lo_q == n_acq + sacs_pkg::START_SAMPLE_STROBE_FULL_CYC)
      else $error("full conversion length wrong");
   chk_start_sample_strobe_byte: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      $rose(eoc_out) && cv && cmd_q[1] |-> lo_q == n_acq + sacs_pkg::START_SAMPLE_STROBE_BYTE_CYC)
      else $error("byte conversion length wrong");
   chk_cal_time: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      $rose(eoc_out) && ok && cmd_q[7:4] == sacs_pkg::OP_CALIBRATE |-> lo_q == sacs_pkg::SYNC_CYC + sacs_pkg::CAL_CYC)
      else $error("calibration length wrong");
   chk_az_time: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      $rose(eoc_out) && ok && cmd_q[7:4] == sacs_pkg::OP_AUTOZERO |-> lo_q == sacs_pkg::SYNC_CYC + sacs_pkg::AZ_CYC)
      else $error("auto-zero length wrong");
   chk_wake_time: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      $rose(eoc_out) && wk_q && rd_q |-> wn_q >= WAKE_CYCLES && wn_q <= WAKE_CYCLES + 8)
      else $error("wake time out of range");
   chk_pd_off: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      power_down_pin_in [*6] |-> !eoc_out) else $error("eoc high while pin forces power down");
   chk_strobe_start: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      $fell(eoc_out) && cv && !power_down_pin_in |-> !$past(start_sample_strobe_n_in, 3))
      else $error("conversion started without strobe");
   chk_ready_low: assert property (@(posedge serial_clock_in) disable iff (!nrst_in)
      !chip_select_n_in && bc_q inside {[4'h1:4'h8]} |-> !data_out_ready_n_out)
      else $error("ready not low in frame");
   chk_ready_max: assert property (@(posedge serial_clock_in) disable iff (!nrst_in)
      rh_q <= 4'h9) else $error("ready high too long");
   chk_oe_frame: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      serial_output_oe_out == !chip_select_n_in) else $error("output enable not following chip select");
endmodule

bind sacs_sequencer sacs_seq_chk #(.WAKE_CYCLES(WAKE_CYCLES)) i_chk (.ref_clk_in(ref_clk_in),
   .nrst_in(nrst_in), .serial_clock_in(serial_clock_in), .chip_select_n_in(chip_select_n_in),
   .serial_input_in(serial_input_in), .start_sample_strobe_n_in(start_sample_strobe_n_in),
   .power_down_pin_in(power_down_pin_in), .data_out_ready_n_out(data_out_ready_n_out),
   .serial_output_oe_out(serial_output_oe_out), .eoc_out(eoc_out));

// ==== sacs_host.sv ====
/*
 sacs_host: serial host model, one command byte per frame, 13 result bits read back.
 assumes: 80 ns serial period; result bits sampled just before each falling edge.
*/
module sacs_host (
   output logic sck_out,
   output logic cs_n_out,
   output logic si_out,
   input wire logic so_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [12:0] rx;
   event done;
   initial begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      si_out = 1'b0;
   end
   // the clock stands still unless asked for
   task automatic clocks(input int n);
      repeat (n) begin
         #40 sck_out = 1'b1;
         #40 sck_out = 1'b0;
      end
   endtask
   task automatic xfer(input logic [7:0] cmd);
      cs_n_out = 1'b0;
      for (int k = 0; k < 13; k++) begin
         si_out = (k < 8) ? cmd[7 - k] : ~si_out;
         #40 sck_out = 1'b1;
         #40 rx = {rx[11:0], so_in};
         sck_out = 1'b0;
      end
      #40 cs_n_out = 1'b1;
      ->done;
   endtask
endmodule

// ==== testbench.sv ====
/*
 testbench: drives the core inputs and a serial host, scores frame data and timing.
 assumes: sacs_host on the link; WAKE_CYCLES shortened to 20.
*/
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WK = 20;
   logic ref_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic strobe_n = 1'b1;
   logic pd = 1'b0;
   logic [12:0] code = 13'h0000;
   logic [12:0] last_res = sacs_pkg::RESULT_RST;
   logic [12:0] exp_q[$];
   logic sck, cs_n, si, so, oe, rdy_n, eoc;
   int bad_count = 0;
   int compares = 0;
   int seed = 30;
   int cyc = 0;
   int lo;
   always #2.5 ref_clk_in = ~ref_clk_in;
   sacs_host i_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so));
   sacs_sequencer #(.WAKE_CYCLES(WK)) i_dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .ce_in(1'b1),
      .serial_clock_in(sck), .chip_select_n_in(cs_n), .serial_input_in(si), .start_sample_strobe_n_in(strobe_n),
      .power_down_pin_in(pd), .analog_code_in(code), .serial_output_out(so), .serial_output_oe_out(oe),
      .data_out_ready_n_out(rdy_n), .eoc_out(eoc));
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic results();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic tick();
      @(posedge ref_clk_in);
      #1;
   endtask
   task automatic frame(input logic [7:0] cmd);
      exp_q.push_back(last_res);
      i_host.xfer(cmd);
      repeat (10) tick();
      check(16'(oe), 16'h0);
   endtask
   // hangs here are cut by the cycle ceiling below
   task automatic wait_eoc(output int n);
      n = 0;
      while (eoc !== 1'b0) tick();
      while (eoc !== 1'b1) begin
         tick();
         n++;
      end
   endtask
   task automatic convert(input logic [1:0] acq, input logic res8, input logic az);
      int want;
      want = (4 << acq) + 2 + (res8 ? 21 : 44) + (az ? sacs_pkg::SYNC_CYC + sacs_pkg::AZ_CYC : 0);
      frame({sacs_pkg::OP_CONVERT, acq, res8, az});
      code = 13'($random(seed));
      strobe_n = 1'b0;
      wait_eoc(lo);
      strobe_n = 1'b1;
      check(16'(lo), 16'(want));
      last_res = res8 ? {code[12:4], 4'h0} : code;
   endtask
   always @(i_host.done) check(16'(i_host.rx), 16'(exp_q.pop_front()));
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end
   initial begin
      i_host.clocks(4);
      tick();
      nrst_in = 1'b1;
      i_host.clocks(3);
      for (int i = 0; i < 8; i++) convert(i[1:0], i[2], 1'b0);
      frame(8'hF0);
      check(16'(eoc), 16'h1);
      fork
         frame({sacs_pkg::OP_CALIBRATE, 4'h0});
         wait_eoc(lo);
      join
      check(16'(lo), 16'(sacs_pkg::SYNC_CYC + sacs_pkg::CAL_CYC));
      fork
         frame({sacs_pkg::OP_AUTOZERO, 4'h0});
         wait_eoc(lo);
      join
      check(16'(lo), 16'(sacs_pkg::SYNC_CYC + sacs_pkg::AZ_CYC));
      frame({sacs_pkg::OP_CONVERT, 4'h0});
      strobe_n = 1'b0;
      repeat (8) tick();
      pd = 1'b1;
      strobe_n = 1'b1;
      repeat (20) tick();
      check(16'(eoc), 16'h0);
      pd = 1'b0;
      wait_eoc(lo);
      check(16'(lo >= WK && lo <= WK + 8), 16'h1);
      frame({sacs_pkg::OP_POWER_DOWN, 4'h0});
      check(16'(eoc), 16'h0);
      lo = 0;
      // wake counted from frame start: the command completes at the eighth rising edge
      fork
         frame({sacs_pkg::OP_POWER_UP, 4'h0});
         while (eoc !== 1'b1) begin
            tick();
            lo++;
         end
      join
      check(16'(lo <= 128 + WK + 8), 16'h1);
      convert(2'h3, 1'b0, 1'b1);
      frame(8'h00);
      results();
   end
endmodule
